// *** logic/umdc_pkg.sv ***
// shared constants and types for the multidrop / direction-control block
// assumes byte addressing on the peripheral bus, one 32-bit word per register
package umdc_pkg;
    localparam logic [31:0] UMDC_CTRL_ADDR    = 32'h4000_804C;
    localparam logic [31:0] UMDC_MATCH_ADDR   = 32'h4000_8050;
    localparam logic [31:0] UMDC_DELAY_ADDR   = 32'h4000_8054;

    localparam int unsigned UMDC_NMM_BIT      = 0;
    localparam int unsigned UMDC_RECEIVER_DISABLE_BIT    = 1;
    localparam int unsigned UMDC_AAD_BIT      = 2;
    localparam int unsigned UMDC_SEL_BIT      = 3;
    localparam int unsigned UMDC_DIRECTION_CONTROL_ENABLE_BIT    = 4;
    localparam int unsigned UMDC_DIRECTION_POLARITY_INVERT_BIT     = 5;
    localparam int unsigned UMDC_CTRL_W       = 6;

    localparam logic [5:0]  UMDC_CTRL_RESET   = 6'h00;
    localparam logic [7:0]  UMDC_MATCH_RESET  = 8'h00;
    localparam logic [7:0]  UMDC_DELAY_RESET  = 8'h00;
    localparam logic [15:0] UMDC_DIV_RESET    = 16'h0000;

    localparam int unsigned UMDC_OVERSAMPLE   = 16;

    typedef enum logic [2:0] {
        DIR_IDLE = 3'b001,
        DIR_SEND = 3'b010,
        DIR_HOLD = 3'b100
    } umdc_dir_state_t;
endpackage : umdc_pkg

// *** logic/umdc_tick_if.sv ***
// timing enables from the baud generator to the port logic
// assumes a single clock; both strobes are one-cycle pulses
`timescale 1ns/1ps
interface umdc_tick_if;
    logic oversampleTick;
    logic baudTick;
    modport gen (output oversampleTick, output baudTick);
    modport use_side (input oversampleTick, input baudTick);
endinterface : umdc_tick_if

// *** logic/umdc_baud_gen.sv ***
// baud generator: divides the clock into a 16x oversample tick and a bit tick
// assumes divisor is stable while characters are in flight; zero acts as one
`timescale 1ns/1ps
module umdc_baud_gen
    import umdc_pkg::*;
#(
    parameter int unsigned DIV_W = 16,
    parameter int unsigned RATIO = UMDC_OVERSAMPLE
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [DIV_W-1:0]  divisorValue,
    umdc_tick_if.gen               ticks
);
    localparam int unsigned PH_W = $clog2(RATIO);
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(RATIO - 1);
    localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);

    logic [DIV_W-1:0] divCnt_ff;
    logic [PH_W-1:0]  phase_ff;
    logic             osTick_ff;
    logic             bitTick_ff;
    logic             wrap;

    assign wrap = (divCnt_ff + DIV_ONE >= divisorValue);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt_ff <= '0;
        end else if (wrap) begin
            divCnt_ff <= '0;
        end else begin
            divCnt_ff <= divCnt_ff + DIV_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            osTick_ff  <= 1'b0;
            bitTick_ff <= 1'b0;
            phase_ff   <= '0;
        end else begin
            osTick_ff  <= wrap;
            bitTick_ff <= wrap && (phase_ff == PH_LAST);
            if (wrap) begin
                phase_ff <= (phase_ff == PH_LAST) ? '0 : phase_ff + PH_W'(1);
            end
        end
    end

    assign ticks.oversampleTick = osTick_ff;
    assign ticks.baudTick       = bitTick_ff;

    property p_bitOnOversample;
        @(posedge clk) disable iff (!rst_b)
        bitTick_ff |-> osTick_ff;
    endproperty
    a_bitOnOversample: assert property (p_bitOnOversample) else $error("bit tick without oversample tick");

    property p_tickSpacing;
        @(posedge clk) disable iff (!rst_b)
        (osTick_ff && divisorValue == DIV_W'(2) && $stable(divisorValue)) |=> !osTick_ff ##1 osTick_ff;
    endproperty
    a_tickSpacing: assert property (p_tickSpacing) else $error("oversample tick spacing wrong");
endmodule : umdc_baud_gen

// *** logic/umdc_core.sv ***
// multidrop address filter and automatic transmit-direction control of a serial port
// assumes the transmitter reports txEmpty and the receiver strobes each assembled character
`timescale 1ns/1ps

// What this block does
// - direction control only while enable bit set
// - bit 3 picks RTS or DTR pin
// - pin low on write, high after last bit
// - polarity bit 5 inverts pin levels
// - hold pin 0..255 baud periods after stop
// - enable overrides others, loopback overrides enable
// - multidrop: stored ninth-bit characters flag parity error
// - receiver disabled: drop data, keep addresses
// - receiver enabled: store all, address flags parity
// - auto detection needs bits 0 and 2
// - compare addresses with match register
// - disabled: discard data and foreign addresses
// - match: store, clear disable, signal ready
// - enabled: foreign address sets disable, dropped
// - match register 8 bits, resets zero
// - delay register 8 bits, resets zero
// - enable and invert bits reset zero
// - baud generator makes 16x tick
// - receiver disable resets to zero
// - control bits 0 to 3 reset zero
module umdc_core
    import umdc_pkg::*;
#(
    parameter int unsigned DIV_W = 16
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [DIV_W-1:0]  divisorValue,
    input  wire logic              txCharWrite,
    input  wire logic              txEmpty,
    input  wire logic              loopbackMode,
    input  wire logic              rtsSoftware_b,
    input  wire logic              dtrSoftware_b,
    output logic                   rtsPin_b,
    output logic                   dtrPin_b,
    input  wire logic              rxCharValid,
    input  wire logic [7:0]        rxCharData,
    input  wire logic              rxCharNinth,
    output logic                   rxStore,
    output logic      [8:0]        rxStoreWord,
    output logic                   rxParityError,
    output logic                   rxDataReady,
    output logic                   oversampleTick
);
    umdc_tick_if ticks ();

    umdc_baud_gen #(
        .DIV_W (DIV_W),
        .RATIO (UMDC_OVERSAMPLE)
    ) u_baud_gen (
        .clk          (clk),
        .rst_b        (rst_b),
        .divisorValue (divisorValue),
        .ticks        (ticks)
    );

    assign oversampleTick = ticks.oversampleTick;

    // ---------------- registers ----------------
    logic [UMDC_CTRL_W-1:0] ctrl_ff;
    logic [7:0]             match_ff;
    logic [7:0]             delay_ff;
    logic [31:0]            prdata_ff;
    logic                   pslverr_ff;
    logic                   wrAccess;
    logic                   rdSetup;
    logic                   hwSetRxdis;
    logic                   hwClrRxdis;

    logic multidropEn;
    logic rxDisabled;
    logic autoAddrEn;
    logic pinSelDtr;
    logic dirEnable;
    logic dirInvert;

    assign multidropEn = ctrl_ff[UMDC_NMM_BIT];
    assign rxDisabled  = ctrl_ff[UMDC_RECEIVER_DISABLE_BIT];
    assign autoAddrEn  = ctrl_ff[UMDC_AAD_BIT];
    assign pinSelDtr   = ctrl_ff[UMDC_SEL_BIT];
    assign dirEnable   = ctrl_ff[UMDC_DIRECTION_CONTROL_ENABLE_BIT];
    assign dirInvert   = ctrl_ff[UMDC_DIRECTION_POLARITY_INVERT_BIT];

    assign wrAccess = psel && penable && pwrite;
    assign rdSetup  = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign prdata   = prdata_ff;
    assign pslverr  = pslverr_ff;

    // hardware updates of the receiver-disable bit win over a same-cycle write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= UMDC_CTRL_RESET;
        end else begin
            if (wrAccess && paddr == UMDC_CTRL_ADDR) begin
                ctrl_ff <= pwdata[UMDC_CTRL_W-1:0];
            end
            if (hwSetRxdis) begin
                ctrl_ff[UMDC_RECEIVER_DISABLE_BIT] <= 1'b1;
            end else if (hwClrRxdis) begin
                ctrl_ff[UMDC_RECEIVER_DISABLE_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            match_ff <= UMDC_MATCH_RESET;
            delay_ff <= UMDC_DELAY_RESET;
        end else if (wrAccess) begin
            if (paddr == UMDC_MATCH_ADDR) begin
                match_ff <= pwdata[7:0];
            end
            if (paddr == UMDC_DELAY_ADDR) begin
                delay_ff <= pwdata[7:0];
            end
        end
    end

    // read data is captured in the setup phase so it comes from a flop in the access phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_ff <= !(paddr == UMDC_CTRL_ADDR || paddr == UMDC_MATCH_ADDR || paddr == UMDC_DELAY_ADDR);
            prdata_ff  <= 32'h0000_0000;
            if (rdSetup) begin
                case (paddr)
                    UMDC_CTRL_ADDR: begin
                        prdata_ff <= {26'h000_0000, ctrl_ff};
                    end
                    UMDC_MATCH_ADDR: begin
                        prdata_ff <= {24'h00_0000, match_ff};
                    end
                    UMDC_DELAY_ADDR: begin
                        prdata_ff <= {24'h00_0000, delay_ff};
                    end
                    default: begin
                        prdata_ff <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // ---------------- receive filter ----------------
    logic isAddress;
    logic addrMatches;
    logic nxt_store;
    logic nxt_parity;
    logic rxStore_ff;
    logic rxParity_ff;
    logic [8:0] rxWord_ff;

    assign isAddress   = rxCharNinth;
    assign addrMatches = (rxCharData == match_ff);

    always_comb begin
        nxt_store  = 1'b0;
        nxt_parity = 1'b0;
        hwSetRxdis = 1'b0;
        hwClrRxdis = 1'b0;
        if (rxCharValid) begin
            if (!multidropEn) begin
                nxt_store = 1'b1;
            end else if (!autoAddrEn) begin
                nxt_store  = isAddress || !rxDisabled;
                nxt_parity = isAddress;
            end else if (rxDisabled) begin
                nxt_store  = isAddress && addrMatches;
                nxt_parity = isAddress && addrMatches;
                hwClrRxdis = isAddress && addrMatches;
            end else begin
                nxt_store  = !(isAddress && !addrMatches);
                nxt_parity = isAddress && addrMatches;
                hwSetRxdis = isAddress && !addrMatches;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxStore_ff  <= 1'b0;
            rxParity_ff <= 1'b0;
            rxWord_ff   <= 9'h000;
        end else begin
            rxStore_ff  <= nxt_store;
            rxParity_ff <= nxt_parity;
            if (nxt_store) begin
                rxWord_ff <= {rxCharNinth, rxCharData};
            end
        end
    end

    assign rxStore       = rxStore_ff;
    assign rxStoreWord   = rxWord_ff;
    assign rxParityError = rxParity_ff;
    assign rxDataReady   = rxStore_ff;

    // ---------------- direction control ----------------
    umdc_dir_state_t dirState_ff;
    umdc_dir_state_t nxt_dirState;
    logic [7:0]      holdCnt_ff;
    logic            busySeen_ff;
    logic            txFinished;
    logic            dirActive;
    logic            dirLevel;

    // the fifo may report empty for a cycle after the write, so wait to see it busy first
    assign txFinished = txEmpty && busySeen_ff && !txCharWrite;

    always_comb begin
        nxt_dirState = dirState_ff;
        case (dirState_ff)
            DIR_IDLE: begin
                if (txCharWrite) begin
                    nxt_dirState = DIR_SEND;
                end
            end
            DIR_SEND: begin
                if (txFinished) begin
                    nxt_dirState = (delay_ff == 8'h00) ? DIR_IDLE : DIR_HOLD;
                end
            end
            DIR_HOLD: begin
                if (txCharWrite) begin
                    nxt_dirState = DIR_SEND;
                end else if (ticks.baudTick && holdCnt_ff == 8'h01) begin
                    nxt_dirState = DIR_IDLE;
                end
            end
            default: begin
                nxt_dirState = DIR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dirState_ff <= DIR_IDLE;
        end else begin
            dirState_ff <= nxt_dirState;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busySeen_ff <= 1'b0;
        end else if (txCharWrite) begin
            busySeen_ff <= 1'b0;
        end else if (!txEmpty) begin
            busySeen_ff <= 1'b1;
        end
    end

    // trailing count is in whole bit times built from sixteen oversample ticks
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            holdCnt_ff <= 8'h00;
        end else if (dirState_ff == DIR_SEND && txFinished) begin
            holdCnt_ff <= delay_ff;
        end else if (dirState_ff == DIR_HOLD && ticks.baudTick && holdCnt_ff != 8'h00) begin
            holdCnt_ff <= holdCnt_ff - 8'h01;
        end
    end

    assign dirActive = (dirState_ff != DIR_IDLE);
    assign dirLevel  = dirInvert ? dirActive : !dirActive;

    // loopback keeps the modem outputs inactive and outranks direction control
    always_comb begin
        rtsPin_b = rtsSoftware_b;
        dtrPin_b = dtrSoftware_b;
        if (loopbackMode) begin
            rtsPin_b = 1'b1;
            dtrPin_b = 1'b1;
        end else if (dirEnable) begin
            if (pinSelDtr) begin
                dtrPin_b = dirLevel;
            end else begin
                rtsPin_b = dirLevel;
            end
        end
    end

    // ---------------- checks ----------------
    property p_offWhenDisabled;
        @(posedge clk) disable iff (!rst_b)
        (!dirEnable && !loopbackMode) |-> (rtsPin_b == rtsSoftware_b && dtrPin_b == dtrSoftware_b);
    endproperty
    a_offWhenDisabled: assert property (p_offWhenDisabled) else $error("pins changed with control off");

    property p_pinSelect;
        @(posedge clk) disable iff (!rst_b)
        (dirEnable && !loopbackMode) |-> (pinSelDtr ? rtsPin_b == rtsSoftware_b : dtrPin_b == dtrSoftware_b);
    endproperty
    a_pinSelect: assert property (p_pinSelect) else $error("unselected pin was driven");

    property p_assertOnWrite;
        @(posedge clk) disable iff (!rst_b)
        (txCharWrite && dirEnable && !dirInvert && !pinSelDtr && !loopbackMode) ##1
            (dirEnable && !dirInvert && !pinSelDtr && !loopbackMode) |-> !rtsPin_b;
    endproperty
    a_assertOnWrite: assert property (p_assertOnWrite) else $error("direction pin not low after write");

    property p_invert;
        @(posedge clk) disable iff (!rst_b)
        (dirEnable && pinSelDtr && !loopbackMode) |-> (dtrPin_b == (dirInvert ? dirActive : !dirActive));
    endproperty
    a_invert: assert property (p_invert) else $error("direction polarity wrong");

    property p_zeroDelay;
        @(posedge clk) disable iff (!rst_b)
        (dirState_ff == DIR_SEND && txFinished && delay_ff == 8'h00) |=> dirState_ff == DIR_IDLE;
    endproperty
    a_zeroDelay: assert property (p_zeroDelay) else $error("zero delay did not release at once");

    property p_holdCount;
        @(posedge clk) disable iff (!rst_b)
        (dirState_ff == DIR_HOLD && !txCharWrite && ticks.baudTick && holdCnt_ff > 8'h01) |=>
            (dirState_ff == DIR_HOLD && holdCnt_ff == $past(holdCnt_ff) - 8'h01);
    endproperty
    a_holdCount: assert property (p_holdCount) else $error("trailing count step wrong");

    property p_loopback;
        @(posedge clk) disable iff (!rst_b)
        loopbackMode |-> (rtsPin_b && dtrPin_b);
    endproperty
    a_loopback: assert property (p_loopback) else $error("loopback did not hold pins");

    property p_dropData;
        @(posedge clk) disable iff (!rst_b)
        (rxCharValid && multidropEn && rxDisabled && !rxCharNinth) |=> (!rxStore && !rxParityError);
    endproperty
    a_dropData: assert property (p_dropData) else $error("data stored while receiver off");

    property p_nmmAddress;
        @(posedge clk) disable iff (!rst_b)
        (rxCharValid && multidropEn && !autoAddrEn && rxCharNinth) |=> (rxStore && rxParityError);
    endproperty
    a_nmmAddress: assert property (p_nmmAddress) else $error("address not stored with parity flag");

    property p_matchEnables;
        @(posedge clk) disable iff (!rst_b)
        (rxCharValid && multidropEn && autoAddrEn && rxDisabled && rxCharNinth && addrMatches) |=>
            (rxStore && !rxDisabled && rxStoreWord == {1'b1, $past(rxCharData)});
    endproperty
    a_matchEnables: assert property (p_matchEnables) else $error("matching address not taken");

    property p_foreignDisables;
        @(posedge clk) disable iff (!rst_b)
        (rxCharValid && multidropEn && autoAddrEn && !rxDisabled && rxCharNinth && !addrMatches) |=>
            (!rxStore && rxDisabled && !rxParityError);
    endproperty
    a_foreignDisables: assert property (p_foreignDisables) else $error("foreign address not rejected");

    c_holdState: cover property (@(posedge clk) disable iff (!rst_b) dirState_ff == DIR_HOLD ##1 dirState_ff == DIR_IDLE);
    c_holdCancel: cover property (@(posedge clk) disable iff (!rst_b) dirState_ff == DIR_HOLD && txCharWrite);
    c_autoMatch: cover property (@(posedge clk) disable iff (!rst_b) hwClrRxdis);
    c_autoReject: cover property (@(posedge clk) disable iff (!rst_b) hwSetRxdis);
endmodule : umdc_core

// *** verification/umdc_master_model.sv ***
// far-side model: the multidrop bus master as seen through the line transceiver and the transmit path
// assumes the bench asks for one character at a time; frameLen sets how long a frame keeps the transmitter busy
`timescale 1ns/1ps
module umdc_master_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        sendReq,
    input  wire logic [8:0]  sendWord,
    input  wire logic        txCharWrite,
    input  wire logic [7:0]  frameLen,
    output logic             rxCharValid,
    output logic [7:0]       rxCharData,
    output logic             rxCharNinth,
    output logic             txEmpty
);
    logic [7:0] frameCnt;

    // ninth bit comes with each character as the bench composed it: one marks an address
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxCharValid <= 1'b0;
            rxCharData  <= 8'h00;
            rxCharNinth <= 1'b0;
        end else if (sendReq) begin
            rxCharValid <= 1'b1;
            {rxCharNinth, rxCharData} <= sendWord;
        end else begin
            // released lines must not keep showing the last character
            rxCharValid <= 1'b0;
            rxCharData  <= ~rxCharData;
            rxCharNinth <= ~rxCharNinth;
        end
    end

    // transmitter busy for frameLen+1 cycles after each write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txEmpty  <= 1'b1;
            frameCnt <= 8'h00;
        end else if (txCharWrite) begin
            txEmpty  <= 1'b0;
            frameCnt <= frameLen;
        end else if (frameCnt != 8'h00) begin
            frameCnt <= frameCnt - 8'h01;
        end else begin
            txEmpty <= 1'b1;
        end
    end
endmodule : umdc_master_model

// *** verification/tb.sv ***
// self-checking bench for umdc_core with the bus master model on its far side
// assumes register access with no wait states and the 25 MHz clock
`timescale 1ns/1ps
module tb;
    import umdc_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, txCharWrite = 1'b0, txEmpty, loopbackMode = 1'b0;
    logic rtsSoftware_b = 1'b1, dtrSoftware_b = 1'b0, rtsPin_b, dtrPin_b;
    logic rxCharValid, rxCharNinth, rxStore, rxParityError, rxDataReady, oversampleTick;
    logic [7:0] rxCharData;
    logic [8:0] rxStoreWord, sendWord = 9'h0;
    logic [15:0] divisorValue = 16'h0001;
    logic sendReq = 1'b0;
    int failCount = 0, samplesChecked = 0, cycleCount = 0;

    always #20 clk = ~clk;

    umdc_core dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .divisorValue(divisorValue),
        .txCharWrite(txCharWrite), .txEmpty(txEmpty), .loopbackMode(loopbackMode), .rtsSoftware_b(rtsSoftware_b),
        .dtrSoftware_b(dtrSoftware_b), .rtsPin_b(rtsPin_b), .dtrPin_b(dtrPin_b), .rxCharValid(rxCharValid),
        .rxCharData(rxCharData), .rxCharNinth(rxCharNinth), .rxStore(rxStore), .rxStoreWord(rxStoreWord),
        .rxParityError(rxParityError), .rxDataReady(rxDataReady), .oversampleTick(oversampleTick));

    umdc_master_model master (.clk(clk), .rst_b(rst_b), .sendReq(sendReq), .sendWord(sendWord),
        .txCharWrite(txCharWrite), .frameLen(8'h0A), .rxCharValid(rxCharValid), .rxCharData(rxCharData),
        .rxCharNinth(rxCharNinth), .txEmpty(txEmpty));

    task automatic conclude();
        if (failCount == 0 && samplesChecked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic checkBit(input string name, input logic exp, input logic got);
        samplesChecked++;
        if (got !== exp) begin
            failCount++;
            $display("BAD %s exp %b got %b", name, exp, got);
        end
    endtask : checkBit

    task automatic checkWord(input string name, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            failCount++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask : checkWord

    task automatic apbWrite(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= 1'b1; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        psel <= 1'b0; penable <= 1'b0;
    endtask : apbWrite

    task automatic readCheck(input logic [31:0] a, input logic [31:0] exp, input logic expErr);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= 1'b0; paddr <= a;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // prdata and pslverr hold through this edge, so taking them here is race-free
        checkWord("prdata", exp, prdata);
        checkBit("pready", 1'b1, pready);
        checkBit("pslverr", expErr, pslverr);
        psel <= 1'b0; penable <= 1'b0;
    endtask : readCheck

    task automatic rxChar(input logic [8:0] w, input logic st, input logic pe);
        @(posedge clk);
        sendWord <= w; sendReq <= 1'b1;
        @(posedge clk);
        sendReq <= 1'b0;
        @(posedge clk);
        #1;
        checkBit("rxStore", st, rxStore);
        checkBit("rxDataReady", st, rxDataReady);
        checkBit("rxParityError", pe, rxParityError);
        if (st) checkWord("rxStoreWord", {23'h0, w}, {23'h0, rxStoreWord});
    endtask : rxChar

    task automatic txWrite();
        @(posedge clk);
        txCharWrite <= 1'b1;
        @(posedge clk);
        txCharWrite <= 1'b0;
        #1;
    endtask : txWrite

    task automatic waitFinish();
        for (int i = 0; i < 300 && txEmpty !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask : waitFinish

    task automatic dirRun(input logic sel, input logic inv, input logic [7:0] dly, input int lo, input int hi);
        int n;
        apbWrite(UMDC_DELAY_ADDR, {24'h0, dly});
        apbWrite(UMDC_CTRL_ADDR, {26'h0, inv, 1'b1, sel, 3'b000});
        #1 checkBit("idlePin", ~inv, sel ? dtrPin_b : rtsPin_b);
        txWrite();
        checkBit("activePin", inv, sel ? dtrPin_b : rtsPin_b);
        checkBit("otherPin", sel ? rtsSoftware_b : dtrSoftware_b, sel ? rtsPin_b : dtrPin_b);
        waitFinish();
        n = 0;
        while (n < 60 && (sel ? dtrPin_b : rtsPin_b) === inv) begin
            @(posedge clk);
            #1 n++;
        end
        checkBit("holdLength", 1'b1, n >= lo && n <= hi);
    endtask : dirRun

    task automatic pinOverride();
        int n;
        apbWrite(UMDC_CTRL_ADDR, 32'h0000_0010);
        txWrite();
        checkBit("rtsAsserted", 1'b0, rtsPin_b);
        loopbackMode <= 1'b1;
        #1 checkBit("rtsLoop", 1'b1, rtsPin_b);
        checkBit("dtrLoop", 1'b1, dtrPin_b);
        @(posedge clk);
        loopbackMode <= 1'b0;
        waitFinish();
        apbWrite(UMDC_CTRL_ADDR, 32'h0000_0000);
        txWrite();
        checkBit("rtsSoftware", rtsSoftware_b, rtsPin_b);
        waitFinish();
        divisorValue <= 16'h0002;
        repeat (4) @(posedge clk);
        n = 0;
        repeat (48) begin
            @(posedge clk);
            #1 n += oversampleTick;
        end
        checkWord("tickCount", 32'h18, n);
        divisorValue <= 16'h0001;
    endtask : pinOverride

    // bounded run: a hang counts as a mismatch
    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            failCount++;
            conclude();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        readCheck(UMDC_CTRL_ADDR, 32'h0, 1'b0);
        readCheck(UMDC_MATCH_ADDR, 32'h0, 1'b0);
        readCheck(UMDC_DELAY_ADDR, 32'h0, 1'b0);
        apbWrite(32'h4000_8058, 32'hFFFF_FFFF);
        readCheck(32'h4000_8058, 32'h0, 1'b1);
        apbWrite(UMDC_CTRL_ADDR, 32'hFFFF_FFFF);
        readCheck(UMDC_CTRL_ADDR, 32'h3F, 1'b0);
        apbWrite(UMDC_MATCH_ADDR, 32'hFFFF_FF5A);
        readCheck(UMDC_MATCH_ADDR, 32'h5A, 1'b0);
        apbWrite(UMDC_CTRL_ADDR, 32'h0);
        rxChar(9'h177, 1'b1, 1'b0);
        apbWrite(UMDC_CTRL_ADDR, 32'h03);
        rxChar(9'h033, 1'b0, 1'b0);
        rxChar(9'h144, 1'b1, 1'b1);
        apbWrite(UMDC_CTRL_ADDR, 32'h01);
        rxChar(9'h055, 1'b1, 1'b0);
        rxChar(9'h166, 1'b1, 1'b1);
        apbWrite(UMDC_CTRL_ADDR, 32'h07);
        rxChar(9'h011, 1'b0, 1'b0);
        rxChar(9'h15B, 1'b0, 1'b0);
        rxChar(9'h15A, 1'b1, 1'b1);
        readCheck(UMDC_CTRL_ADDR, 32'h05, 1'b0);
        rxChar(9'h022, 1'b1, 1'b0);
        rxChar(9'h1A5, 1'b0, 1'b0);
        readCheck(UMDC_CTRL_ADDR, 32'h07, 1'b0);
        apbWrite(UMDC_CTRL_ADDR, 32'h06);
        rxChar(9'h033, 1'b1, 1'b0);
        for (int k = 0; k < 4; k++)
            dirRun(k[0], k[1], 8'h00, 1, 1);
        dirRun(1'b0, 1'b0, 8'h02, 17, 34);
        pinOverride();
        conclude();
    end
endmodule : tb
